// [inc/ddrg_pkg.sv]
/*
 ddrg_pkg: constants, opcodes, tables and types for the ddr read output and command guard.
 assumes: every user writes ddrg_pkg::name, nothing is imported.
*/
package ddrg_pkg;
   localparam int DATA_W      = 8;
   localparam int BUF_DEPTH   = 2;
   localparam int PTR_W       = 1;
   localparam int CNT_W       = 2;
   localparam logic [1:0] BUF_FULL = 2'h2;
   // config register field positions
   localparam int CFG_LC_MSB  = 7;
   localparam int CFG_LC_LSB  = 6;
   localparam int CFG_QE_BIT  = 1;
   // synchroniser bit positions and reset value (cs_n and data lines 2/3 idle high)
   localparam int SYNC_W      = 8;
   localparam int S_OFF       = 0;
   localparam int S_LOW       = 1;
   localparam int S_POR       = 2;
   localparam int S_CSN       = 3;
   localparam int S_DL2       = 4;
   localparam int S_DL3       = 5;
   localparam int S_TAKE      = 6;
   localparam int S_DDR       = 7;
   localparam logic [7:0] SYNC_RST = 8'h38;
   // opcodes
   localparam logic [7:0] OP_PAGE_PROG    = 8'h02;
   localparam logic [7:0] OP_QUAD_PROG    = 8'h32;
   localparam logic [7:0] OP_SECT_ERASE   = 8'hD8;
   localparam logic [7:0] OP_PARAM_ERASE  = 8'h20;
   localparam logic [7:0] OP_BULK_ERASE   = 8'h60;
   localparam logic [7:0] OP_REG_WRITE    = 8'h01;
   localparam logic [7:0] OP_QUAD_OUT_RD  = 8'h6B;
   localparam logic [7:0] OP_QUAD_IO_RD   = 8'hEB;
   localparam logic [7:0] OP_DDR_FAST_RD  = 8'h0D;
   localparam logic [7:0] OP_DDR_DUAL_RD  = 8'hBD;
   localparam logic [7:0] OP_DDR_QUAD_RD  = 8'hED;
   // address cycles for a 24 bit address, per output width
   localparam logic [4:0] ADDR_CYC_SINGLE = 5'h0C;
   localparam logic [4:0] ADDR_CYC_DUAL   = 5'h06;
   localparam logic [4:0] ADDR_CYC_QUAD   = 5'h03;
   // per latency code tables, one nibble per code, code 0 in the low nibble
   localparam logic [15:0] MODE_SINGLE    = 16'h0444;
   localparam logic [15:0] MODE_DUAL      = 16'h0222;
   localparam logic [15:0] MODE_QUAD      = 16'h0111;
   localparam logic [15:0] LAT_SINGLE     = 16'h8654;
   localparam logic [15:0] LAT_DUAL       = 16'h7654;
   localparam logic [15:0] LAT_QUAD       = 16'h7651;
   typedef enum logic [4:0] {
      LK_CMD  = 5'h01,
      LK_ADDR = 5'h02,
      LK_LAT  = 5'h04,
      LK_OUT  = 5'h08,
      LK_DROP = 5'h10
   } ddrg_link_state_type;
   typedef enum logic [2:0] {
      WD_SINGLE = 3'h1,
      WD_DUAL   = 3'h2,
      WD_QUAD   = 3'h4
   } ddrg_width_type;
endpackage

// [inc/ddrg_stream_if.sv]
/*
 ddrg_stream_if: byte stream with valid and ready.
 assumes: source and sink share clk_sys; a byte moves when valid and ready are both high.
*/
interface ddrg_stream_if;
   logic [ddrg_pkg::DATA_W-1:0] data;
   logic                        valid;
   logic                        ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

// [src/ddrg_sync.sv]
/*
 ddrg_sync: three flip-flop synchroniser plus an output flop per bit, output moves once stages two and three agree.
 assumes: inputs are levels or toggles slower than a few clk_sys cycles.
*/
module ddrg_sync #(
   parameter int                WIDTH     = 1,
   parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
   input  logic              clk_sys,
   input  logic              rst,
   input  logic [WIDTH-1:0]  d,
   output logic [WIDTH-1:0]  q
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic s1_reg;
         logic s2_reg;
         logic s3_reg;
         logic q_reg;
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               s1_reg <= RESET_VAL[i];
               s2_reg <= RESET_VAL[i];
               s3_reg <= RESET_VAL[i];
               q_reg  <= RESET_VAL[i];
            end else begin
               s1_reg <= d[i];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
               // filters a single metastable sample
               if (s2_reg == s3_reg) begin
                  q_reg <= s3_reg;
               end
            end
         end
         assign q[i] = q_reg;
      end
   endgenerate
endmodule

// [src/ddrg_buf.sv]
/*
 ddrg_buf: two-entry buffer for read bytes, flip-flop storage addressed by index.
 assumes: both sides on clk_sys; flush empties it and wins over a push in the same cycle.
*/
module ddrg_buf (
   input  logic                 clk_sys,
   input  logic                 rst,
   input  logic                 flush,
   ddrg_stream_if.snk           in_s,
   ddrg_stream_if.src           out_s
);
   logic [ddrg_pkg::DATA_W-1:0]  mem_reg [ddrg_pkg::BUF_DEPTH];
   logic [ddrg_pkg::PTR_W-1:0]   wr_ptr_reg;
   logic [ddrg_pkg::PTR_W-1:0]   rd_ptr_reg;
   logic [ddrg_pkg::CNT_W-1:0]   count_reg;
   logic [ddrg_pkg::CNT_W-1:0]   count_next;
   wire                          push;
   wire                          pop;
   localparam logic [ddrg_pkg::PTR_W-1:0] PTR_ONE = 1'h1;

   assign in_s.ready  = (count_reg != ddrg_pkg::BUF_FULL);
   assign out_s.valid = (count_reg != '0);
   assign out_s.data  = mem_reg[rd_ptr_reg];
   assign push        = in_s.valid & in_s.ready;
   assign pop         = out_s.valid & out_s.ready;

   always_comb begin
      case ({push, pop})
         2'b10:   count_next = count_reg + 2'h1;
         2'b01:   count_next = count_reg - 2'h1;
         default: count_next = count_reg;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_s.data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst || flush) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + PTR_ONE;
         rd_ptr_reg <= rd_ptr_reg + PTR_ONE;
         count_reg  <= count_next;
         if (!push) wr_ptr_reg <= wr_ptr_reg;
         if (!pop) rd_ptr_reg <= rd_ptr_reg;
      end
   end
endmodule

// [src/ddrg_top.sv]
/*
 ddrg_top: serial flash interface tail: command capture and guards, ddr read latency,
 ddr single/dual/quad output, read byte hand-over from the core.
 assumes: host drives sck and cs_n, sck stands still while cs_n is high, cs_n stays high
 far longer than four clk_sys cycles between frames, first sck edge comes more than four
 clk_sys cycles after cs_n falls.
*/
// Function
// - ddr dual output on lines 0 and 1
// - ddr dual leaves lines 2 and 3 undriven
// - ddr quad drives all four lines
// - output continues until cs_n rises
// - config bits 7:6 hold latency code
// - latency code sets mode and dummy cycles
// - quad enable gates quad commands, hold, protect
// - ddr quad read needs quad enable
// - supply off: no response, no program
// - refuse commands until power-on reset done
// - low supply: ignore commands
// - check write-class clock count multiple of eight
// - bad count dropped silently, no status
// - after latency enter matching ddr output
module ddrg_top (
   input  logic                          clk_sys,
   input  logic                          rst,
   input  logic                          sck,
   input  logic                          cs_n,
   input  logic [3:0]                    data_line_in,
   output logic [3:0]                    data_line_out,
   output logic [3:0]                    data_line_oe,
   input  logic                          supply_off,
   input  logic                          supply_low,
   input  logic                          por_done,
   input  logic [7:0]                    first_config_register,
   input  logic [ddrg_pkg::DATA_W-1:0]   rd_data,
   input  logic                          rd_valid,
   output logic                          rd_ready,
   output logic                          cmd_valid,
   output logic [7:0]                    cmd_opcode,
   output logic                          ddr_read_active,
   output logic                          wp_active,
   output logic                          hold_active
);
   function automatic logic is_write_class(input logic [7:0] op);
      return (op == ddrg_pkg::OP_PAGE_PROG) || (op == ddrg_pkg::OP_QUAD_PROG) ||
             (op == ddrg_pkg::OP_SECT_ERASE) || (op == ddrg_pkg::OP_PARAM_ERASE) ||
             (op == ddrg_pkg::OP_BULK_ERASE) || (op == ddrg_pkg::OP_REG_WRITE);
   endfunction

   function automatic logic needs_quad(input logic [7:0] op);
      return (op == ddrg_pkg::OP_QUAD_PROG) || (op == ddrg_pkg::OP_QUAD_OUT_RD) ||
             (op == ddrg_pkg::OP_QUAD_IO_RD) || (op == ddrg_pkg::OP_DDR_QUAD_RD);
   endfunction

   function automatic logic is_ddr_read(input logic [7:0] op);
      return (op == ddrg_pkg::OP_DDR_FAST_RD) || (op == ddrg_pkg::OP_DDR_DUAL_RD) ||
             (op == ddrg_pkg::OP_DDR_QUAD_RD);
   endfunction

   function automatic ddrg_pkg::ddrg_width_type ddr_width(input logic [7:0] op);
      if (op == ddrg_pkg::OP_DDR_QUAD_RD) return ddrg_pkg::WD_QUAD;
      if (op == ddrg_pkg::OP_DDR_DUAL_RD) return ddrg_pkg::WD_DUAL;
      return ddrg_pkg::WD_SINGLE;
   endfunction

   function automatic logic [4:0] code_nib(input logic [15:0] tbl, input logic [1:0] code);
      return {1'b0, tbl[{code, 2'b00} +: 4]};
   endfunction

   // clk_sys side
   logic [ddrg_pkg::SYNC_W-1:0]  sync_in;
   logic [ddrg_pkg::SYNC_W-1:0]  sync_out;
   logic                         off_s;
   logic                         low_s;
   logic                         por_s;
   logic                         csn_s;
   logic                         take_s;
   logic                         csn_d_reg;
   logic                         accept_snap_reg;
   logic                         qe_snap_reg;
   logic [1:0]                   lc_snap_reg;
   logic                         cmd_valid_reg;
   logic [7:0]                   cmd_opcode_reg;
   logic                         seen_reg;
   logic [7:0]                   nbyte_reg;
   logic                         nvalid_reg;
   logic                         ddr_active_reg;
   logic                         wp_reg;
   logic                         hold_reg;
   wire                          frame_end;
   wire                          accept_now;
   wire                          take_ev;
   wire                          fwd_ok;
   // sck side
   ddrg_pkg::ddrg_link_state_type st_reg;
   ddrg_pkg::ddrg_link_state_type st_next;
   ddrg_pkg::ddrg_width_type      wm_reg;
   ddrg_pkg::ddrg_width_type      wm_next;
   logic [4:0]                   cnt_reg;
   logic [4:0]                   cnt_next;
   logic                         ddr_rd_reg;
   logic                         ddr_rd_next;
   logic                         in_frame_reg;
   logic [7:0]                   op_reg;
   logic [2:0]                   cnt8_reg;
   logic                         acc_reg;
   logic [7:0]                   grp_reg;
   logic [7:0]                   rem_reg;
   logic [1:0]                   bcnt_reg;
   logic                         take_tgl_reg;
   logic [3:0]                   oe_reg;
   wire                          link_clr;
   wire                          first;
   wire  [7:0]                   op_shift;
   wire                          opcode_done;
   wire                          cmd_ok;
   wire  [4:0]                   addr_cyc;
   wire  [4:0]                   lat_cyc;
   wire  [7:0]                   cur;
   wire  [7:0]                   cur_shift;
   wire  [1:0]                   last_b;
   wire  [3:0]                   oe_mask;

   ddrg_stream_if buf_in ();
   ddrg_stream_if buf_out ();

   assign sync_in = {ddr_rd_reg, take_tgl_reg, data_line_in[3], data_line_in[2], cs_n,
                     por_done, supply_low, supply_off};

   ddrg_sync #(
      .WIDTH     (ddrg_pkg::SYNC_W),
      .RESET_VAL (ddrg_pkg::SYNC_RST)
   ) u_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .d       (sync_in),
      .q       (sync_out)
   );

   assign off_s  = sync_out[ddrg_pkg::S_OFF];
   assign low_s  = sync_out[ddrg_pkg::S_LOW];
   assign por_s  = sync_out[ddrg_pkg::S_POR];
   assign csn_s  = sync_out[ddrg_pkg::S_CSN];
   assign take_s = sync_out[ddrg_pkg::S_TAKE];

   assign buf_in.data  = rd_data;
   assign buf_in.valid = rd_valid;
   assign rd_ready     = buf_in.ready;

   ddrg_buf u_buf (
      .clk_sys (clk_sys),
      .rst     (rst),
      .flush   (frame_end),
      .in_s    (buf_in),
      .out_s   (buf_out)
   );

   assign frame_end  = ~csn_d_reg & csn_s;
   assign accept_now = por_s & ~off_s & ~low_s;
   // sck stopped before cs_n rose, so the frame summary registers are steady here
   assign fwd_ok     = acc_reg & accept_now & (~is_write_class(op_reg) | (cnt8_reg == 3'h0));
   assign take_ev    = take_s ^ seen_reg;
   assign buf_out.ready = ~csn_s & ~nvalid_reg & ~take_ev;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         csn_d_reg       <= 1'b1;
         accept_snap_reg <= 1'b0;
         qe_snap_reg     <= 1'b0;
         lc_snap_reg     <= 2'h0;
      end else begin
         csn_d_reg <= csn_s;
         // frozen during a frame so the sck side reads steady values
         if (csn_s) begin
            accept_snap_reg <= accept_now;
            qe_snap_reg     <= first_config_register[ddrg_pkg::CFG_QE_BIT];
            lc_snap_reg     <= first_config_register[ddrg_pkg::CFG_LC_MSB:ddrg_pkg::CFG_LC_LSB];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cmd_valid_reg  <= 1'b0;
         cmd_opcode_reg <= 8'h00;
      end else begin
         cmd_valid_reg <= frame_end & fwd_ok;
         if (frame_end & fwd_ok) begin
            cmd_opcode_reg <= op_reg;
         end
      end
   end

   // read byte hand-over: sck side toggles when it has taken nbyte_reg
   always_ff @(posedge clk_sys) begin
      if (rst || csn_s) begin
         seen_reg   <= 1'b0;
         nvalid_reg <= 1'b0;
      end else if (take_ev) begin
         seen_reg   <= take_s;
         nvalid_reg <= 1'b0;
      end else if (buf_out.valid && !nvalid_reg) begin
         nvalid_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         nbyte_reg <= 8'h00;
      end else if (buf_out.valid && buf_out.ready) begin
         nbyte_reg <= buf_out.data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ddr_active_reg <= 1'b0;
         wp_reg         <= 1'b0;
         hold_reg       <= 1'b0;
      end else begin
         ddr_active_reg <= sync_out[ddrg_pkg::S_DDR] & ~csn_s;
         wp_reg         <= ~first_config_register[ddrg_pkg::CFG_QE_BIT] & ~sync_out[ddrg_pkg::S_DL2];
         hold_reg       <= ~first_config_register[ddrg_pkg::CFG_QE_BIT] & ~sync_out[ddrg_pkg::S_DL3] & ~csn_s;
      end
   end

   assign cmd_valid       = cmd_valid_reg;
   assign cmd_opcode      = cmd_opcode_reg;
   assign ddr_read_active = ddr_active_reg;
   assign wp_active       = wp_reg;
   assign hold_active     = hold_reg;

   // sck side: cs_n high ends the frame and returns the link to standby
   assign link_clr    = cs_n | rst;
   assign first       = ~in_frame_reg;
   assign op_shift    = first ? {7'h00, data_line_in[0]} : {op_reg[6:0], data_line_in[0]};
   assign opcode_done = (st_reg == ddrg_pkg::LK_CMD) && (cnt_reg == 5'h07);
   assign cmd_ok      = accept_snap_reg & ~(needs_quad(op_shift) & ~qe_snap_reg);

   assign addr_cyc = (ddr_width(op_shift) == ddrg_pkg::WD_QUAD) ?
                        5'(ddrg_pkg::ADDR_CYC_QUAD + code_nib(ddrg_pkg::MODE_QUAD, lc_snap_reg)) :
                     (ddr_width(op_shift) == ddrg_pkg::WD_DUAL) ?
                        5'(ddrg_pkg::ADDR_CYC_DUAL + code_nib(ddrg_pkg::MODE_DUAL, lc_snap_reg)) :
                        5'(ddrg_pkg::ADDR_CYC_SINGLE + code_nib(ddrg_pkg::MODE_SINGLE, lc_snap_reg));
   assign lat_cyc  = (wm_reg == ddrg_pkg::WD_QUAD) ? code_nib(ddrg_pkg::LAT_QUAD, lc_snap_reg) :
                     (wm_reg == ddrg_pkg::WD_DUAL) ? code_nib(ddrg_pkg::LAT_DUAL, lc_snap_reg) :
                                                     code_nib(ddrg_pkg::LAT_SINGLE, lc_snap_reg);

   always_comb begin
      st_next     = st_reg;
      cnt_next    = cnt_reg;
      wm_next     = wm_reg;
      ddr_rd_next = ddr_rd_reg;
      case (st_reg)
         ddrg_pkg::LK_CMD: begin
            if (cnt_reg == 5'h07) begin
               if (cmd_ok && is_ddr_read(op_shift)) begin
                  st_next     = ddrg_pkg::LK_ADDR;
                  cnt_next    = 5'(addr_cyc - 5'h01);
                  wm_next     = ddr_width(op_shift);
                  ddr_rd_next = 1'b1;
               end else begin
                  st_next = ddrg_pkg::LK_DROP;
               end
            end else begin
               cnt_next = 5'(cnt_reg + 5'h01);
            end
         end
         ddrg_pkg::LK_ADDR: begin
            if (cnt_reg == 5'h00) begin
               st_next  = ddrg_pkg::LK_LAT;
               cnt_next = 5'(lat_cyc - 5'h01);
            end else begin
               cnt_next = 5'(cnt_reg - 5'h01);
            end
         end
         ddrg_pkg::LK_LAT: begin
            if (cnt_reg == 5'h00) begin
               st_next = ddrg_pkg::LK_OUT;
            end else begin
               cnt_next = 5'(cnt_reg - 5'h01);
            end
         end
         ddrg_pkg::LK_OUT:  st_next = ddrg_pkg::LK_OUT;
         ddrg_pkg::LK_DROP: st_next = ddrg_pkg::LK_DROP;
         default:           st_next = ddrg_pkg::LK_DROP;
      endcase
   end

   always_ff @(posedge sck or posedge link_clr) begin
      if (link_clr) begin
         st_reg       <= ddrg_pkg::LK_CMD;
         cnt_reg      <= 5'h00;
         wm_reg       <= ddrg_pkg::WD_SINGLE;
         ddr_rd_reg   <= 1'b0;
         in_frame_reg <= 1'b0;
      end else begin
         st_reg       <= st_next;
         cnt_reg      <= cnt_next;
         wm_reg       <= wm_next;
         ddr_rd_reg   <= ddr_rd_next;
         in_frame_reg <= 1'b1;
      end
   end

   // frame summary survives cs_n high so clk_sys can judge the finished command
   always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
         op_reg   <= 8'h00;
         cnt8_reg <= 3'h0;
         acc_reg  <= 1'b0;
      end else begin
         if (st_reg == ddrg_pkg::LK_CMD) begin
            op_reg <= op_shift;
         end
         cnt8_reg <= first ? 3'h1 : 3'(cnt8_reg + 3'h1);
         acc_reg  <= first ? 1'b0 : (opcode_done ? cmd_ok : acc_reg);
      end
   end

   // ddr output: groups load on the falling edge, first half shown while sck is low
   assign last_b    = (wm_reg == ddrg_pkg::WD_QUAD) ? 2'h0 : (wm_reg == ddrg_pkg::WD_DUAL) ? 2'h1 : 2'h3;
   assign cur       = (bcnt_reg == 2'h0) ? nbyte_reg : rem_reg;
   assign cur_shift = (wm_reg == ddrg_pkg::WD_QUAD) ? 8'h00 :
                      (wm_reg == ddrg_pkg::WD_DUAL) ? {cur[3:0], 4'h0} : {cur[5:0], 2'h0};
   assign oe_mask   = (wm_reg == ddrg_pkg::WD_QUAD) ? 4'hF :
                      (wm_reg == ddrg_pkg::WD_DUAL) ? 4'h3 : 4'h2;

   always_ff @(negedge sck or posedge link_clr) begin
      if (link_clr) begin
         grp_reg      <= 8'h00;
         rem_reg      <= 8'h00;
         bcnt_reg     <= 2'h0;
         take_tgl_reg <= 1'b0;
         oe_reg       <= 4'h0;
      end else if (st_reg == ddrg_pkg::LK_OUT) begin
         grp_reg  <= cur;
         rem_reg  <= cur_shift;
         bcnt_reg <= (bcnt_reg == last_b) ? 2'h0 : 2'(bcnt_reg + 2'h1);
         oe_reg   <= oe_mask;
         if (bcnt_reg == 2'h0) begin
            take_tgl_reg <= ~take_tgl_reg;
         end
      end
   end

   always_comb begin
      case (wm_reg)
         ddrg_pkg::WD_QUAD: data_line_out = sck ? grp_reg[3:0] : grp_reg[7:4];
         ddrg_pkg::WD_DUAL: data_line_out = {2'h0, sck ? grp_reg[5:4] : grp_reg[7:6]};
         default:           data_line_out = {2'h0, sck ? grp_reg[6] : grp_reg[7], 1'b0};
      endcase
   end

   // a dead supply silences the pins even mid-frame
   assign data_line_oe = oe_reg & {4{~off_s}};
endmodule

// [tb/ddrg_host.sv]
/* ddrg_host: host on the link, frames commands on sck, cs_n and data lines 0-3.
   assumes: sck 160 ns, idle low, stopped while cs_n is high; pin levels are resolved here. */
module ddrg_host (
   output logic       sck,
   output logic       cs_n,
   output logic [3:0] data_line_in,
   input  logic [3:0] data_line_out,
   input  logic [3:0] data_line_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] hv;
   logic [7:0] smp[$];
   // a released line toggles so a stale level never passes for data
   assign data_line_in = (data_line_oe & data_line_out) | (~data_line_oe & hv);
   initial {sck, cs_n, hv} = 6'h1C;
   task automatic frame(input logic [7:0] op, input int n, input int rel, input int out);
      smp.delete();
      cs_n = 1'b0;
      #100;
      for (int i = 0; i < n; i++) begin
         hv = i < 8 ? {3'h6, op[7-i]} : i < rel ? 4'hC : ~hv;
         #79;
         if (i >= out) smp.push_back({data_line_oe, data_line_in});
         #1 sck = 1'b1;
         #79;
         if (i >= out) smp.push_back({data_line_oe, data_line_in});
         if (i >= rel) hv = ~hv;
         #1 sck = 1'b0;
      end
      #80 cs_n = 1'b1;
   endtask
endmodule

// [tb/ddrg_top_chk.sv]
/* ddrg_top_chk: concurrent checks on the ports of ddrg_top.
   assumes: bound into ddrg_top, one clk_sys domain, rst synchronous and active high. */
module ddrg_top_chk (
   input logic       clk_sys,
   input logic       rst,
   input logic       cs_n,
   input logic [3:0] data_line_oe,
   input logic       supply_off,
   input logic       supply_low,
   input logic       por_done,
   input logic       cmd_valid,
   input logic       ddr_read_active,
   input logic [7:0] first_config_register,
   input logic       wp_active,
   input logic       hold_active
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_oe_group; data_line_oe inside {4'h0, 4'h2, 4'h3, 4'hF}; endproperty
   property p_idle_off; cs_n && $past(cs_n) |-> data_line_oe == 4'h0; endproperty
   property p_oe_read; data_line_oe != 4'h0 |-> ddr_read_active; endproperty
   // pin flags pass four flops first, so the guards are judged after eight cycles
   property p_off_quiet; supply_off [*8] |-> data_line_oe == 4'h0 && !cmd_valid; endproperty
   property p_low_quiet; supply_low [*8] |-> !cmd_valid; endproperty
   property p_por_quiet; !por_done [*8] |-> data_line_oe == 4'h0 && !cmd_valid; endproperty
   property p_pulse; cmd_valid |=> !cmd_valid; endproperty
   property p_cmd_late; cmd_valid |-> cs_n && $past(cs_n, 3); endproperty
   // quad enable one cycle old, so the registered flags have seen it
   property p_qe_free;
      first_config_register[1] && $past(first_config_register[1]) |-> !wp_active && !hold_active;
   endproperty
   a_oe_group: assert property (p_oe_group) else $error("oe group");
   a_idle_off: assert property (p_idle_off) else $error("oe idle");
   a_oe_read: assert property (p_oe_read) else $error("oe no read");
   a_off_quiet: assert property (p_off_quiet) else $error("supply off");
   a_low_quiet: assert property (p_low_quiet) else $error("supply low");
   a_por_quiet: assert property (p_por_quiet) else $error("por");
   a_pulse: assert property (p_pulse) else $error("cmd pulse");
   a_cmd_late: assert property (p_cmd_late) else $error("cmd early");
   a_qe_free: assert property (p_qe_free) else $error("hold or protect with quad");
   c_wp: cover property (wp_active);
   c_quad: cover property (data_line_oe == 4'hF);
   c_dual: cover property (data_line_oe == 4'h3);
   c_cmd: cover property (cmd_valid);
endmodule

// [tb/test_ddrg_top.sv]
/* test_ddrg_top: self-checking bench for ddrg_top with a host model on the link.
   assumes: package, host model and checker compiled first. */
module test_ddrg_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic       clk_sys, rst, sck, cs_n, supply_off, supply_low, por_done, rd_valid, rd_ready, cmd_valid;
   logic [3:0] data_line_in, data_line_out, data_line_oe;
   logic [7:0] cfg_reg, rd_data, cmd_opcode, last_op;
   int         bad_count = 0, check_count = 0, cycle_count = 0, cmd_count = 0;
   logic [7:0] wr[6] = '{ddrg_pkg::OP_PAGE_PROG, ddrg_pkg::OP_QUAD_PROG, ddrg_pkg::OP_SECT_ERASE,
                         ddrg_pkg::OP_PARAM_ERASE, ddrg_pkg::OP_BULK_ERASE, ddrg_pkg::OP_REG_WRITE};
   ddrg_host u_host (.sck, .cs_n, .data_line_in, .data_line_out, .data_line_oe);
   ddrg_top DUT (.clk_sys, .rst, .sck, .cs_n, .data_line_in, .data_line_out, .data_line_oe, .supply_off,
      .supply_low, .por_done, .first_config_register(cfg_reg), .rd_data, .rd_valid, .rd_ready, .cmd_valid,
      .cmd_opcode, .ddr_read_active(), .wp_active(), .hold_active());
   initial clk_sys = 1'b0;
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycle_count++;
      if (cmd_valid === 1'b1) begin
         cmd_count++;
         last_op = cmd_opcode;
      end
      if (cycle_count == 40000) begin
         bad_count++;
         test_done();
      end
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   function automatic int tbl(input logic [15:0] t, input logic [1:0] c);
      return int'(t[4*c +: 4]);
   endfunction
   // core data is withdrawn right after cs_n rises so the flush leaves no stale byte
   task automatic xfer(input logic [7:0] op, input int n, input int rel, input int out, input logic fwd);
      int c0;
      c0 = cmd_count;
      u_host.frame(op, n, rel, out);
      step(1);
      rd_valid = 1'b0;
      step(11);
      check(8'(cmd_count - c0), {7'h0, fwd}, "forward");
      if (fwd) check(last_op, op, "opcode");
   endtask
   task automatic rframe(input logic [7:0] op, input int bps, input logic ok);
      logic [7:0] e, got;
      int         rel, lat;
      rel = 8 + int'(bps == 4 ? ddrg_pkg::ADDR_CYC_QUAD : bps == 2 ? ddrg_pkg::ADDR_CYC_DUAL
            : ddrg_pkg::ADDR_CYC_SINGLE) + tbl(bps == 4 ? ddrg_pkg::MODE_QUAD : bps == 2
            ? ddrg_pkg::MODE_DUAL : ddrg_pkg::MODE_SINGLE, cfg_reg[7:6]);
      lat = tbl(bps == 4 ? ddrg_pkg::LAT_QUAD : bps == 2 ? ddrg_pkg::LAT_DUAL : ddrg_pkg::LAT_SINGLE, cfg_reg[7:6]);
      rd_data = 8'($urandom);
      rd_valid = 1'b1;
      xfer(op, rel + lat + 8 / bps, rel, rel + lat, ok);
      foreach (u_host.smp[k]) begin
         e = u_host.smp[k];
         check({4'h0, e[7:4]}, ok ? (bps == 4 ? 8'h0F : bps == 2 ? 8'h03 : 8'h02) : 8'h00, "oe");
         got = (got << bps) | 8'((e[3:0] >> (bps == 1)) & 4'((1 << bps) - 1));
         if (ok && (k + 1) % (8 / bps) == 0) check(got, rd_data, "byte");
      end
   endtask
   initial begin
      {rst, supply_off, supply_low, por_done, rd_valid} = 5'h10;
      {cfg_reg, rd_data} = 16'h0200;
      void'($urandom(34019));
      step(12);
      rst = 1'b0;
      rd_valid = 1'b1;
      step(6);
      check({7'h0, rd_ready}, 8'h00, "buffer full");
      xfer(ddrg_pkg::OP_PAGE_PROG, 16, 99, 99, 1'b0);
      por_done = 1'b1;
      step(8);
      foreach (wr[i]) begin
         xfer(wr[i], 8 * $urandom_range(2, 4), 99, 99, 1'b1);
         xfer(wr[i], 8 * $urandom_range(2, 4) + $urandom_range(1, 7), 99, 99, 1'b0);
      end
      for (int c = 0; c < 4; c++) begin
         cfg_reg = {2'(c), 6'h02};
         step(10);
         rframe(ddrg_pkg::OP_DDR_FAST_RD, 1, 1'b1);
         rframe(ddrg_pkg::OP_DDR_DUAL_RD, 2, 1'b1);
         rframe(ddrg_pkg::OP_DDR_QUAD_RD, 4, 1'b1);
      end
      xfer(ddrg_pkg::OP_QUAD_OUT_RD, 16, 99, 99, 1'b1);
      xfer(ddrg_pkg::OP_QUAD_IO_RD, 16, 99, 99, 1'b1);
      cfg_reg = 8'h40;
      step(10);
      rframe(ddrg_pkg::OP_DDR_QUAD_RD, 4, 1'b0);
      xfer(ddrg_pkg::OP_QUAD_PROG, 16, 99, 99, 1'b0);
      xfer(ddrg_pkg::OP_QUAD_OUT_RD, 16, 99, 99, 1'b0);
      xfer(ddrg_pkg::OP_QUAD_IO_RD, 16, 99, 99, 1'b0);
      cfg_reg = 8'h02;
      supply_low = 1'b1;
      step(10);
      xfer(ddrg_pkg::OP_SECT_ERASE, 16, 99, 99, 1'b0);
      supply_low = 1'b0;
      supply_off = 1'b1;
      step(10);
      rframe(ddrg_pkg::OP_DDR_QUAD_RD, 4, 1'b0);
      test_done();
   end
endmodule
bind ddrg_top ddrg_top_chk u_chk (.clk_sys, .rst, .cs_n, .data_line_oe, .supply_off, .supply_low, .por_done,
   .cmd_valid, .ddr_read_active, .first_config_register, .wp_active, .hold_active);
